// ===== lsir_bank.sv
// lsir_bank: line status, interrupt status, jitter and error count bank.
// assumes inputs synchronous to sys_clk, events as one-cycle pulses.
`timescale 1ns/1ps

// one link's bank; all registers of one link live here
module lsir_link
  import lsir_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic [7:0] ofs,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic rd,
  input wire logic second_tick,
  input wire logic mclk,
  input wire logic line_clk,
  input wire lsir_line_in_t line_in,
  output logic [7:0] rd_val,
  output logic irq,
  output logic ref_clock_out
);
  logic [7:0] ja_tx_ctrl; // b5 selects peak mode
  logic [7:0] ja_rx_ctrl;
  logic [7:0] maint_ctrl; // exz enable, report mode, trigger
  logic [7:0] irq_en_0;
  logic [7:0] irq_en_1;
  logic [7:0] edge_sel;
  logic [7:0] ref_ctrl;
  logic [7:0] irq_st_0; // latched status changes
  logic [7:0] irq_st_1; // latched error events
  logic df_q; // previous status, for change detection
  logic loss_q;
  logic [15:0] err_count; // internal excessive-zero counter
  logic [15:0] count_shadow; // copy that software reads
  logic trf_q; // previous transfer trigger
  logic [6:0] tx_max, tx_min, rx_max, rx_min; // peak trackers
  logic [6:0] tx_meas, rx_meas; // measured fields
  logic [7:0] next_st_0, next_st_1;
  logic df_chg, loss_chg, count_on, count_wrap, copy_now;
  logic tx_rd, rx_rd, tx_clr, rx_clr, tx_peak, rx_peak;

  function automatic logic hit(input logic [7:0] a, input logic [7:0] b);
    return a == b;
  endfunction

  // control registers, only documented bits kept
  // reserved bits dropped
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      ja_tx_ctrl <= LSIR_RESET_BYTE;
      ja_rx_ctrl <= LSIR_RESET_BYTE;
      maint_ctrl <= LSIR_RESET_BYTE;
      irq_en_0 <= LSIR_RESET_BYTE;
      irq_en_1 <= LSIR_RESET_BYTE;
      edge_sel <= LSIR_RESET_BYTE;
      ref_ctrl <= LSIR_RESET_BYTE;
    end else if (wr) begin
      if (hit(ofs, LSIR_OFS_JA_TX_CTRL)) ja_tx_ctrl <= wdata & 8'h20;
      if (hit(ofs, LSIR_OFS_JA_RX_CTRL)) ja_rx_ctrl <= wdata & 8'h20;
      if (hit(ofs, LSIR_OFS_MAINT_CTRL)) maint_ctrl <= wdata & LSIR_MASK_MAINT;
      if (hit(ofs, LSIR_OFS_IRQ_EN_0)) irq_en_0 <= wdata & LSIR_MASK_ST0;
      if (hit(ofs, LSIR_OFS_IRQ_EN_1)) irq_en_1 <= wdata & LSIR_MASK_ST1;
      if (hit(ofs, LSIR_OFS_EDGE_SEL)) edge_sel <= wdata & LSIR_MASK_ST0;
      if (hit(ofs, LSIR_OFS_REF_CTRL)) ref_ctrl <= wdata & 8'h01;
    end
  end

  // previous status levels
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      df_q <= 1'b0;
      loss_q <= 1'b0;
    end else begin
      df_q <= line_in.driver_fail;
      loss_q <= line_in.signal_loss;
    end
  end

  assign df_chg = (line_in.driver_fail & ~df_q) |
                  (edge_sel[LSIR_B_DF] & ~line_in.driver_fail & df_q);
  assign loss_chg = (line_in.signal_loss & ~loss_q) |
                    (edge_sel[LSIR_B_LOSS] & ~line_in.signal_loss & loss_q);

  // next latched status; a new event beats a same-cycle clear
  always_comb begin
    next_st_0 = irq_st_0;
    next_st_1 = irq_st_1;
    if (wr && hit(ofs, LSIR_OFS_IRQ_STATUS_0)) next_st_0 = irq_st_0 & ~wdata;
    if (wr && hit(ofs, LSIR_OFS_IRQ_STATUS_1)) next_st_1 = irq_st_1 & ~wdata;
    next_st_0[LSIR_B_DF] = next_st_0[LSIR_B_DF] | df_chg;
    next_st_0[LSIR_B_LOSS] = next_st_0[LSIR_B_LOSS] | loss_chg;
    next_st_1[LSIR_B_DAC] = next_st_1[LSIR_B_DAC] | line_in.template_overflow;
    next_st_1[LSIR_B_TJA] = next_st_1[LSIR_B_TJA] | line_in.tx_fifo_slip;
    next_st_1[LSIR_B_RJA] = next_st_1[LSIR_B_RJA] | line_in.rx_fifo_slip;
    next_st_1[LSIR_B_EXZ] = next_st_1[LSIR_B_EXZ] | line_in.excess_zero;
    next_st_1[LSIR_B_CV] = next_st_1[LSIR_B_CV] | line_in.bipolar_violation;
    next_st_1[LSIR_B_CNTOV] = next_st_1[LSIR_B_CNTOV] | count_wrap;
  end

  // latched status registers
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      irq_st_0 <= LSIR_RESET_BYTE;
      irq_st_1 <= LSIR_RESET_BYTE;
    end else begin
      irq_st_0 <= next_st_0;
      irq_st_1 <= next_st_1;
    end
  end

  assign irq = |(irq_st_0 & irq_en_0) | |(irq_st_1 & irq_en_1);

  // counting needs the exz enable code of 01
  assign count_on = maint_ctrl[3:2] == LSIR_EXZ_COUNT_ON;
  assign count_wrap = count_on && line_in.excess_zero && err_count == LSIR_COUNT_MAX;

  // internal error counter, wraps through zero
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      err_count <= 16'h0000;
    end else if (count_on && line_in.excess_zero) begin
      err_count <= err_count + 16'h0001;
    end
  end

  // auto each second, manual on trigger rise
  assign copy_now = maint_ctrl[LSIR_B_MD] ? second_tick
                                          : (maint_ctrl[LSIR_B_TRF] & ~trf_q);
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      trf_q <= 1'b0;
      count_shadow <= 16'h0000;
    end else begin
      trf_q <= maint_ctrl[LSIR_B_TRF];
      if (copy_now) count_shadow <= err_count;
    end
  end

  // jitter reads and clears
  assign tx_rd = rd && hit(ofs, LSIR_OFS_TX_JITTER);
  assign rx_rd = rd && hit(ofs, LSIR_OFS_RX_JITTER);
  assign tx_clr = wr && hit(ofs, LSIR_OFS_TX_JITTER) && wdata != 8'h00;
  assign rx_clr = wr && hit(ofs, LSIR_OFS_RX_JITTER) && wdata != 8'h00;
  assign tx_peak = ja_tx_ctrl[LSIR_B_PEAK];
  assign rx_peak = ja_rx_ctrl[LSIR_B_PEAK];

  // peak trackers restart from the live spacing after a read or clear
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      tx_max <= 7'h00;
      tx_min <= 7'h7f;
    end else if (tx_rd || tx_clr || !tx_peak) begin
      tx_max <= line_in.tx_pointer_spacing;
      tx_min <= line_in.tx_pointer_spacing;
    end else begin
      if (line_in.tx_pointer_spacing > tx_max) tx_max <= line_in.tx_pointer_spacing;
      if (line_in.tx_pointer_spacing < tx_min) tx_min <= line_in.tx_pointer_spacing;
    end
  end
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      rx_max <= 7'h00;
      rx_min <= 7'h7f;
    end else if (rx_rd || rx_clr || !rx_peak) begin
      rx_max <= line_in.rx_pointer_spacing;
      rx_min <= line_in.rx_pointer_spacing;
    end else begin
      if (line_in.rx_pointer_spacing > rx_max) rx_max <= line_in.rx_pointer_spacing;
      if (line_in.rx_pointer_spacing < rx_min) rx_min <= line_in.rx_pointer_spacing;
    end
  end

  // measured fields; cleared value stands until the next update
  // live spacing; peak-to-peak since read
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      tx_meas <= 7'h00;
      rx_meas <= 7'h00;
    end else begin
      if (tx_clr) tx_meas <= 7'h00;
      else if (tx_peak) tx_meas <= (tx_max > tx_min) ? tx_max - tx_min : 7'h00;
      else tx_meas <= line_in.tx_pointer_spacing;
      if (rx_clr) rx_meas <= 7'h00;
      else if (rx_peak) rx_meas <= (rx_max > rx_min) ? rx_max - rx_min : 7'h00;
      else rx_meas <= line_in.rx_pointer_spacing;
    end
  end

  // read mux, unmapped offsets read zero
  always_comb begin
    case (ofs)
      LSIR_OFS_JA_TX_CTRL: rd_val = ja_tx_ctrl;
      LSIR_OFS_JA_RX_CTRL: rd_val = ja_rx_ctrl;
      LSIR_OFS_MAINT_CTRL: rd_val = maint_ctrl;
      LSIR_OFS_IRQ_EN_0: rd_val = irq_en_0;
      LSIR_OFS_IRQ_EN_1: rd_val = irq_en_1;
      LSIR_OFS_EDGE_SEL: rd_val = edge_sel;
      // driver failure b2; signal loss b0
      LSIR_OFS_LINE_STATUS_0: rd_val = {5'h00, line_in.driver_fail, 1'b0, line_in.signal_loss};
      LSIR_OFS_LINE_STATUS_GAIN: rd_val = {3'h0, line_in.rx_gain_code};
      LSIR_OFS_TX_JITTER: rd_val = {1'b0, tx_meas};
      LSIR_OFS_RX_JITTER: rd_val = {1'b0, rx_meas};
      LSIR_OFS_IRQ_STATUS_0: rd_val = irq_st_0;
      LSIR_OFS_IRQ_STATUS_1: rd_val = irq_st_1;
      LSIR_OFS_COUNT_HIGH: rd_val = count_shadow[15:8];
      LSIR_OFS_COUNT_LOW: rd_val = count_shadow[7:0];
      LSIR_OFS_REF_CTRL: rd_val = ref_ctrl;
      default: rd_val = 8'h00;
    endcase
  end

  // during loss pick mclk or steady high
  assign ref_clock_out = line_in.signal_loss ? (ref_ctrl[LSIR_B_REFH] | mclk) : line_clk;

  // checks
  a_rise_latch: assert property (@(posedge sys_clk) disable iff (rst)
    $rose(line_in.signal_loss) |=> irq_st_0[LSIR_B_LOSS])
    else $error("loss rise not latched");
  a_fall_latch: assert property (@(posedge sys_clk) disable iff (rst)
    $fell(line_in.driver_fail) && !edge_sel[LSIR_B_DF] && !irq_st_0[LSIR_B_DF]
    && !(wr && ofs == LSIR_OFS_IRQ_STATUS_0) |=> !irq_st_0[LSIR_B_DF])
    else $error("driver fall latched in rising mode");
  a_hold_latch: assert property (@(posedge sys_clk) disable iff (rst)
    irq_st_1[LSIR_B_CV] && !(wr && ofs == LSIR_OFS_IRQ_STATUS_1) |=> irq_st_1[LSIR_B_CV])
    else $error("latched bit dropped without clear");
  a_clear_latch: assert property (@(posedge sys_clk) disable iff (rst)
    wr && ofs == LSIR_OFS_IRQ_STATUS_1 && wdata[LSIR_B_TJA] && !line_in.tx_fifo_slip
    |=> !irq_st_1[LSIR_B_TJA])
    else $error("write one did not clear");
  a_slip_set: assert property (@(posedge sys_clk) disable iff (rst)
    line_in.rx_fifo_slip |=> irq_st_1[LSIR_B_RJA])
    else $error("receive slip not latched");
  a_wrap_set: assert property (@(posedge sys_clk) disable iff (rst)
    count_on && line_in.excess_zero && err_count == LSIR_COUNT_MAX
    |=> err_count == 16'h0000 && irq_st_1[LSIR_B_CNTOV])
    else $error("counter overflow not flagged");
  a_manual_copy: assert property (@(posedge sys_clk) disable iff (rst)
    !maint_ctrl[LSIR_B_MD] && $rose(maint_ctrl[LSIR_B_TRF]) |=> count_shadow == $past(err_count))
    else $error("manual transfer missed");
  a_live_space: assert property (@(posedge sys_clk) disable iff (rst)
    !tx_peak && !tx_clr |=> tx_meas == $past(line_in.tx_pointer_spacing))
    else $error("live spacing wrong");
  a_jitter_clr: assert property (@(posedge sys_clk) disable iff (rst)
    rx_clr |=> rx_meas == 7'h00)
    else $error("jitter clear failed");
  a_irq_out: assert property (@(posedge sys_clk) disable iff (rst)
    irq_st_0[LSIR_B_LOSS] && irq_en_0[LSIR_B_LOSS] |-> irq)
    else $error("enabled event without interrupt");
  a_ref_high: assert property (@(posedge sys_clk) disable iff (rst)
    line_in.signal_loss && ref_ctrl[LSIR_B_REFH] |-> ref_clock_out)
    else $error("ref output not high on loss");
  c_both_edges: cover property (@(posedge sys_clk) disable iff (rst)
    edge_sel[LSIR_B_LOSS] && $fell(line_in.signal_loss));
  c_count_wrap: cover property (@(posedge sys_clk) disable iff (rst) count_wrap);
  c_peak_read: cover property (@(posedge sys_clk) disable iff (rst) tx_peak && tx_rd);
  c_set_vs_clear: cover property (@(posedge sys_clk) disable iff (rst)
    line_in.bipolar_violation && wr && ofs == LSIR_OFS_IRQ_STATUS_1);
endmodule

// top: register port, link decode, one-second tick, interrupt pin
module lsir_bank
  import lsir_pkg::*;
#(
  parameter int REPORT_CYCLES = LSIR_REPORT_CYCLES, // one second of sys_clk
  parameter int LINKS = 2
)(
  input wire logic sys_clk,
  input wire logic rst,
  input wire lsir_req_t req,
  output logic [7:0] rdata,
  input wire lsir_line_in_t line_in_0,
  input wire lsir_line_in_t line_in_1,
  input wire logic mclk,
  input wire logic [1:0] line_clk,
  output logic irq_n,
  output logic ref_clock_out_a,
  output logic ref_clock_out_b
);
  logic [31:0] tick_cnt; // one-second divider, shared by both links
  logic second_tick;
  logic [7:0] rd_val [LINKS];
  logic [LINKS-1:0] irq_link, ref_out;
  lsir_line_in_t line_in [LINKS];

  assign line_in[0] = line_in_0;
  assign line_in[1] = line_in_1;

  // free running divider; a shared tick keeps both links in step
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      tick_cnt <= 32'h0000_0000;
    end else if (second_tick) begin
      tick_cnt <= 32'h0000_0000;
    end else begin
      tick_cnt <= tick_cnt + 32'h0000_0001;
    end
  end
  assign second_tick = tick_cnt == 32'(REPORT_CYCLES - 1);

  // one bank per link, address bit 8 selects
  for (genvar i = 0; i < LINKS; i++) begin : g_link
    lsir_link u_link (
      .sys_clk(sys_clk),
      .rst(rst),
      .ofs(req.addr[7:0]),
      .wdata(req.wdata),
      .wr(req.wr && req.addr[LSIR_LINK_BIT] == 1'(i)),
      .rd(req.rd && req.addr[LSIR_LINK_BIT] == 1'(i)),
      .second_tick(second_tick),
      .mclk(mclk),
      .line_clk(line_clk[i]),
      .line_in(line_in[i]),
      .rd_val(rd_val[i]),
      .irq(irq_link[i]),
      .ref_clock_out(ref_out[i])
    );
  end

  // read data stands one cycle after the strobe, zero otherwise
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      rdata <= LSIR_RESET_BYTE;
    end else if (req.rd) begin
      rdata <= rd_val[req.addr[LSIR_LINK_BIT]];
    end else begin
      rdata <= LSIR_RESET_BYTE;
    end
  end

  // active-low pin, either link may pull it
  assign irq_n = ~|irq_link;
  assign ref_clock_out_a = ref_out[0];
  assign ref_clock_out_b = ref_out[1];
endmodule

// ===== lsir_pkg.sv
// lsir_pkg: constants, offsets and carrier types of the line status bank.
// assumes a byte-wide register port; bit 8 of the address picks the link.
package lsir_pkg;
  // clock rate and report period
  localparam int LSIR_SYS_CLK_HZ = 40_000_000;
  localparam int LSIR_REPORT_PERIOD_MS = 1000;
  localparam int LSIR_REPORT_CYCLES = LSIR_SYS_CLK_HZ / 1000 * LSIR_REPORT_PERIOD_MS;
  // link selector and per-link offsets
  localparam int LSIR_ADDR_W = 9;
  localparam int LSIR_LINK_BIT = 8;
  localparam logic [7:0] LSIR_OFS_JA_TX_CTRL = 8'h21;
  localparam logic [7:0] LSIR_OFS_JA_RX_CTRL = 8'h27;
  localparam logic [7:0] LSIR_OFS_MAINT_CTRL = 8'h31;
  localparam logic [7:0] LSIR_OFS_IRQ_EN_0 = 8'h33;
  localparam logic [7:0] LSIR_OFS_IRQ_EN_1 = 8'h34;
  localparam logic [7:0] LSIR_OFS_EDGE_SEL = 8'h35;
  localparam logic [7:0] LSIR_OFS_LINE_STATUS_0 = 8'h36;
  localparam logic [7:0] LSIR_OFS_LINE_STATUS_GAIN = 8'h37;
  localparam logic [7:0] LSIR_OFS_TX_JITTER = 8'h38;
  localparam logic [7:0] LSIR_OFS_RX_JITTER = 8'h39;
  localparam logic [7:0] LSIR_OFS_IRQ_STATUS_0 = 8'h3a;
  localparam logic [7:0] LSIR_OFS_IRQ_STATUS_1 = 8'h3b;
  localparam logic [7:0] LSIR_OFS_COUNT_HIGH = 8'h3c;
  localparam logic [7:0] LSIR_OFS_COUNT_LOW = 8'h3d;
  localparam logic [7:0] LSIR_OFS_REF_CTRL = 8'h3e;
  // field positions
  localparam int LSIR_B_LOSS = 0;
  localparam int LSIR_B_DF = 2;
  localparam int LSIR_B_PEAK = 5;
  localparam int LSIR_B_TRF = 0;
  localparam int LSIR_B_MD = 1;
  localparam int LSIR_B_REFH = 0;
  // status-1 field positions
  localparam int LSIR_B_CNTOV = 0;
  localparam int LSIR_B_CV = 1;
  localparam int LSIR_B_EXZ = 2;
  localparam int LSIR_B_RJA = 4;
  localparam int LSIR_B_TJA = 5;
  localparam int LSIR_B_DAC = 6;
  // writable masks, reserved bits drop out
  localparam logic [7:0] LSIR_MASK_ST0 = 8'h05;
  localparam logic [7:0] LSIR_MASK_ST1 = 8'h77;
  localparam logic [7:0] LSIR_MASK_MAINT = 8'h0f;
  localparam logic [1:0] LSIR_EXZ_COUNT_ON = 2'h1;
  localparam logic [7:0] LSIR_RESET_BYTE = 8'h00;
  localparam logic [15:0] LSIR_COUNT_MAX = 16'hffff;
  // line-side inputs of one link
  typedef struct packed {
    logic driver_fail;
    logic signal_loss;
    logic [4:0] rx_gain_code;
    logic [6:0] tx_pointer_spacing;
    logic [6:0] rx_pointer_spacing;
    logic template_overflow;
    logic tx_fifo_slip;
    logic rx_fifo_slip;
    logic excess_zero;
    logic bipolar_violation;
  } lsir_line_in_t;
  // register port request
  typedef struct packed {
    logic [LSIR_ADDR_W-1:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } lsir_req_t;
endpackage

// ===== testbench.sv
// testbench: self-checking bench for the line status bank, both links.
// assumes lsir_pkg and lsir_bank are compiled first; fast report period.
`timescale 1ns/1ps

`define CHK(nm, e, g) begin total_checks++; if ((g) !== (e)) begin num_errors++; \
  $display("FAIL %s expected %h seen %h", nm, e, g); end end

module testbench;
  import lsir_pkg::*;
  localparam int RC = 64; // short report period keeps the run brief
  logic sys_clk; // 40 MHz system clock
  logic rst; // async reset, active high
  logic mclk; // master clock for the ref outputs
  logic [1:0] line_clk; // per-link normal ref source
  lsir_req_t req; // register port request
  logic [7:0] rdata; // read data, one cycle after the strobe
  lsir_line_in_t li [2]; // line-side inputs per link
  logic irq_n; // interrupt, active low
  logic ref_clock_out_a; // link 0 ref output
  logic ref_clock_out_b; // link 1 ref output
  int num_errors = 0;
  int total_checks = 0;
  int seed = 97; // fixed seed keeps runs repeatable
  logic [7:0] got; // last read value
  logic [6:0] sp [4]; // spacing samples for the peak test
  logic [4:0] g; // gain code under test
  int k; // excess zero count

  lsir_bank #(.REPORT_CYCLES(RC), .LINKS(2)) dut (
    .sys_clk(sys_clk), .rst(rst), .req(req), .rdata(rdata),
    .line_in_0(li[0]), .line_in_1(li[1]), .mclk(mclk), .line_clk(line_clk),
    .irq_n(irq_n), .ref_clock_out_a(ref_clock_out_a), .ref_clock_out_b(ref_clock_out_b));

  // clock generator
  initial begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end

  // side clocks move on the falling edge so checks after rising edges are race-free
  always @(negedge sys_clk) begin
    mclk <= ~mclk;
    line_clk <= 2'($random(seed));
  end

  // expected status-1 bit for each event input, pulse index k
  function automatic logic [7:0] ev_bit(int k);
    case (k)
      0: return 8'h40;
      1: return 8'h20;
      2: return 8'h10;
      3: return 8'h04;
      default: return 8'h02;
    endcase
  endfunction

  // expected peak-to-peak spacing over the samples
  function automatic logic [7:0] peak(logic [6:0] v [4]);
    logic [6:0] mx;
    logic [6:0] mn;
    mx = v[0];
    mn = v[0];
    for (int i = 1; i < 4; i++) begin
      if (v[i] > mx) mx = v[i];
      if (v[i] < mn) mn = v[i];
    end
    return {1'b0, mx - mn};
  endfunction

  // one-cycle write strobe
  task automatic wr(input logic [8:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    req.addr <= a;
    req.wdata <= d;
    req.wr <= 1'b1;
    @(posedge sys_clk);
    req.wr <= 1'b0;
  endtask

  // one-cycle read strobe; data taken in the following cycle only
  task automatic rchk(input logic [8:0] a, input logic [7:0] e, input string nm);
    @(posedge sys_clk);
    req.addr <= a;
    req.rd <= 1'b1;
    @(posedge sys_clk);
    req.rd <= 1'b0;
    #1 got = rdata;
    `CHK(nm, e, got)
  endtask

  // hold excess zero high for n sampled edges on link 0
  task automatic zeros(input int n);
    @(posedge sys_clk);
    li[0].excess_zero <= 1'b1;
    repeat (n) @(posedge sys_clk);
    li[0].excess_zero <= 1'b0;
  endtask

  task automatic test_done;
    if (num_errors == 0 && total_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  // watchdog: the full run needs roughly 66k cycles
  initial begin
    #(90000 * 25);
    num_errors++;
    $display("FAIL watchdog expected done seen timeout");
    test_done();
  end

  initial begin
    rst = 1'b1;
    req = '0;
    mclk = 1'b0;
    line_clk = 2'b00;
    li[0] = '0;
    li[1] = '0;
    repeat (8) @(posedge sys_clk);
    rst <= 1'b0;
    for (int l = 0; l < 2; l++) begin
      // offsets 0x36 to 0x3e read zero out of reset, unmapped 0x3f too
      for (int o = 8'h36; o <= 8'h3f; o++) rchk({l[0], o[7:0]}, 8'h00, "reset");
      // gain codes, 0x15 and all ones first then random
      for (int i = 0; i < 4; i++) begin
        g = (i == 0) ? 5'h15 : (i == 1) ? 5'h1f : 5'($random(seed));
        @(posedge sys_clk);
        li[l].rx_gain_code <= g;
        rchk({l[0], 8'h37}, {3'b000, g}, "gain");
      end
      // rising status latches with edge select 0
      @(posedge sys_clk);
      li[l].driver_fail <= 1'b1;
      li[l].signal_loss <= 1'b1;
      rchk({l[0], 8'h36}, 8'h05, "status");
      rchk({l[0], 8'h3a}, 8'h05, "latch rise");
      wr({l[0], 8'h3a}, 8'h01);
      rchk({l[0], 8'h3a}, 8'h04, "w1c one bit");
      wr({l[0], 8'h3a}, 8'h04);
      wr({l[0], 8'h36}, 8'hff);
      rchk({l[0], 8'h36}, 8'h05, "ro write");
      // falling change must not latch while edge select is 0
      @(posedge sys_clk);
      li[l].driver_fail <= 1'b0;
      rchk({l[0], 8'h3a}, 8'h00, "no fall latch");
      wr({l[0], 8'h35}, 8'hff);
      rchk({l[0], 8'h35}, 8'h05, "edge sel mask");
      @(posedge sys_clk);
      li[l].signal_loss <= 1'b0;
      rchk({l[0], 8'h3a}, 8'h01, "fall latch");
      // interrupt pin follows enabled latched bits
      `CHK("irq idle", 1'b1, irq_n)
      wr({l[0], 8'h33}, 8'h01);
      #1 `CHK("irq on", 1'b0, irq_n)
      wr({l[0], 8'h3a}, 8'h01);
      #1 `CHK("irq off", 1'b1, irq_n)
      wr({l[0], 8'h33}, 8'h00);
      // each event pulse sets its own status-1 bit
      for (int e = 0; e < 5; e++) begin
        @(posedge sys_clk);
        li[l][4 - e] <= 1'b1;
        @(posedge sys_clk);
        li[l][4 - e] <= 1'b0;
        rchk({l[0], 8'h3b}, ev_bit(e), "event");
        wr({l[0], 8'h3b}, ev_bit(e));
      end
      // live pointer spacing
      sp[0] = 7'($random(seed));
      @(posedge sys_clk);
      li[l].tx_pointer_spacing <= sp[0];
      li[l].rx_pointer_spacing <= sp[0] ^ 7'h55;
      rchk({l[0], 8'h38}, {1'b0, sp[0]}, "tx live");
      rchk({l[0], 8'h39}, {1'b0, sp[0] ^ 7'h55}, "rx live");
      // peak mode: restart trackers by reading, then sweep the spacing
      wr({l[0], 8'h21}, 8'h20);
      wr({l[0], 8'h27}, 8'h20);
      li[l].rx_pointer_spacing <= sp[0];
      // rx tracker saw the old live value before the step to sp[0]
      sp[1] = sp[0] ^ 7'h55;
      sp[2] = sp[0];
      sp[3] = sp[0];
      rchk({l[0], 8'h38}, 8'h00, "tx restart");
      rchk({l[0], 8'h39}, peak(sp), "rx restart");
      for (int i = 1; i < 4; i++) begin
        sp[i] = 7'($random(seed));
        @(posedge sys_clk);
        li[l].tx_pointer_spacing <= sp[i];
        li[l].rx_pointer_spacing <= sp[i];
      end
      // let the last sample reach the trackers before reading
      repeat (2) @(posedge sys_clk);
      rchk({l[0], 8'h38}, peak(sp), "tx peak");
      rchk({l[0], 8'h39}, peak(sp), "rx peak");
      // a step in spacing, then a written one restarts both measures
      @(posedge sys_clk);
      li[l].tx_pointer_spacing <= sp[3] ^ 7'h2a;
      li[l].rx_pointer_spacing <= sp[3] ^ 7'h2a;
      wr({l[0], 8'h38}, 8'h01);
      wr({l[0], 8'h39}, 8'h01);
      rchk({l[0], 8'h38}, 8'h00, "tx clear");
      rchk({l[0], 8'h39}, 8'h00, "rx clear");
      wr({l[0], 8'h21}, 8'h00);
      wr({l[0], 8'h27}, 8'h00);
      // ref outputs during loss: master clock, then held high
      @(posedge sys_clk);
      li[l].signal_loss <= 1'b1;
      @(posedge sys_clk);
      #1 `CHK("ref mclk", mclk, l ? ref_clock_out_b : ref_clock_out_a)
      wr({l[0], 8'h3e}, 8'hff);
      rchk({l[0], 8'h3e}, 8'h01, "ref ctrl");
      `CHK("ref high", 1'b1, l ? ref_clock_out_b : ref_clock_out_a)
      @(posedge sys_clk);
      li[l].signal_loss <= 1'b0;
      @(posedge sys_clk);
      #1 `CHK("ref line", line_clk[l], l ? ref_clock_out_b : ref_clock_out_a)
      wr({l[0], 8'h3e}, 8'h00);
      wr({l[0], 8'h35}, 8'h00);
      wr({l[0], 8'h3a}, 8'hff);
    end
    // manual transfer of the excess zero count
    k = ($random(seed) & 15) + 1;
    wr(9'h031, 8'h04);
    zeros(k);
    rchk(9'h03d, 8'h00, "no transfer");
    wr(9'h031, 8'h05);
    repeat (2) @(posedge sys_clk);
    rchk(9'h03c, 8'h00, "count high");
    rchk(9'h03d, 8'(k), "count low");
    // wrap the 16-bit counter and land on 3
    zeros(65536 - k + 3);
    wr(9'h031, 8'h04);
    wr(9'h031, 8'h05);
    repeat (2) @(posedge sys_clk);
    rchk(9'h03c, 8'h00, "wrap high");
    rchk(9'h03d, 8'h03, "wrap low");
    rchk(9'h03b, 8'h05, "overflow");
    wr(9'h03b, 8'hff);
    // automatic report without any trigger
    wr(9'h031, 8'h06);
    zeros(5);
    repeat (RC + 4) @(posedge sys_clk);
    rchk(9'h03d, 8'h08, "auto report");
    test_done();
  end
endmodule
